// file: core/usb_host_channel_setup.sv
// Strobed register access was decided locally.
`timescale 1ns/1ps
module usb_host_channel_setup
  import usb_chan_pkg::*;
#(
  parameter int LW = 10
)(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [9:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  input  wire logic [7:0]    fifo_rdata,
  output logic      [7:0]    fifo_wdata,
  output logic               fifo_push,
  output logic               fifo_pop,
  input  wire logic          fifo_full,
  input  wire logic          fifo_empty,
  input  wire logic [LW-1:0] fifo_level,
  input  wire logic [LW-1:0] fifo_space,
  input  wire logic [1:0]    dma_req,
  input  wire logic [1:0]    dma_direction_bit,
  output logic      [LW-1:0] dma_leftover_count0,
  output logic      [LW-1:0] dma_leftover_count1,
  output logic               fifo_event_full,
  output logic               fifo_event_empty,
  output logic               fifo_event_not_empty,
  input  wire logic          setup_sequencer_launch,
  input  wire logic          sequencer_is_out,
  input  wire logic          bulk_only_active,
  input  wire logic          bulk_data_phase,
  output logic               txn_start,
  output logic               txn_is_out,
  output logic               txn_full_speed,
  output logic               txn_toggle,
  output logic      [10:0]   txn_len,
  output logic               txn_zero_len,
  input  wire logic          txn_done,
  input  wire logic          txn_acked,
  input  wire logic [10:0]   txn_bytes,
  input  wire logic          txn_stall,
  input  wire logic          txn_timeout,
  input  wire logic          txn_crc_err,
  input  wire logic          txn_stuff_err,
  input  wire logic          txn_pid_fail,
  input  wire logic          txn_pid_bad,
  input  wire logic          txn_toggle_err
);
  typedef struct packed {
    eng_state_type st;
    logic [7:0]    link;
    logic [3:0]    ack_lim;
    logic [1:0]    speed;
    logic          tog;
    logic          run;
    logic [1:0]    token;
    logic          auto_z;
    logic          unlim;
    logic [9:0]    mps;
    logic [31:0]   remain;
    logic [2:0]    ev;
    logic [2:0]    rc;
    logic [3:0]    ack_cnt;
    logic          zlp_pend;
    logic          acked;
    logic [10:0]   got;
    logic [7:0]    rdata;
    logic [7:0]    wdata;
    logic          start;
    logic          is_out;
    logic          fs;
    logic          tog_out;
    logic [10:0]   len;
    logic          zlen;
  } core_state_type;
  core_state_type s_ff, nxt_s;
  logic [2:0]     code;
  logic [31:0]    new_rem;
  logic           fin;
  logic [3:0]     ack_next;

  fifo_join_if #(.LW(LW)) jif ();

  // Keep only the highest requested data link
  function automatic logic [7:0] link_pick(input logic [7:0] w);
    logic [7:0] r;
    r = w & JOIN_MASK;
    if (w[DMA1_BIT]) begin
      r[3:0] = 4'h8;
    end else if (w[DMA0_BIT]) begin
      r[3:0] = 4'h4;
    end else if (w[CRD_BIT]) begin
      r[3:0] = 4'h2;
    end else if (w[CWR_BIT]) begin
      r[3:0] = 4'h1;
    end
    return r;
  endfunction

  // Size of the next data packet
  function automatic logic [10:0] pkt_len(input logic [31:0] rem, input logic [9:0] mps, input logic unl);
    if (unl || rem >= {22'h00_0000, mps}) begin
      return {1'b0, mps};
    end
    return rem[10:0];
  endfunction

  // ==========================================================
  // Submodules
  result_classify u_cls (
    .clk        (clk),
    .rst_n      (rst_n),
    .done       (txn_done),
    .stall      (txn_stall),
    .timeout    (txn_timeout),
    .crc_err    (txn_crc_err),
    .stuff_err  (txn_stuff_err),
    .pid_fail   (txn_pid_fail),
    .pid_bad    (txn_pid_bad),
    .toggle_err (txn_toggle_err),
    .code       (code)
  );

  fifo_join_route #(.LW(LW)) u_route (
    .clk   (clk),
    .rst_n (rst_n),
    .jif   (jif.route)
  );

  // Router inputs
  assign jif.join_bits = s_ff.link;
  assign jif.dma_req   = dma_req;
  assign jif.dma_dir   = dma_direction_bit;
  assign jif.cpu_rd    = reg_rd && reg_addr == RDP_ADDR;
  assign jif.cpu_wr    = reg_wr && reg_addr == WRP_ADDR;
  assign jif.full      = fifo_full;
  assign jif.empty     = fifo_empty;
  assign jif.level     = fifo_level;
  assign jif.space     = fifo_space;

  // ==========================================================
  // Register writes, reads and transaction engine
  always_comb begin
    nxt_s    = s_ff;
    new_rem  = 32'h0000_0000;
    fin      = 1'b0;
    ack_next = 4'h0;
    nxt_s.start = 1'b0;
    nxt_s.rdata = 8'h00;
    // Software writes
    if (reg_wr) begin
      case (reg_addr)
        JOIN_ADDR: nxt_s.link = link_pick(reg_wdata);
        CFGA_ADDR: begin
          nxt_s.ack_lim = reg_wdata[ACK_LSB +: 4];
          nxt_s.speed   = reg_wdata[SPD_LSB +: 2];
          nxt_s.tog     = reg_wdata[TOG_BIT];
          nxt_s.run     = reg_wdata[RUN_BIT];
        end
        CFGB_ADDR: begin
          nxt_s.token  = reg_wdata[TOK_LSB +: 2];
          nxt_s.auto_z = reg_wdata[AUTOZ_BIT];
          nxt_s.unlim  = reg_wdata[UNLIM_BIT];
        end
        MPSH_ADDR: nxt_s.mps[9:8] = reg_wdata[1:0];
        MPSL_ADDR: nxt_s.mps[7:0] = reg_wdata;
        LEN3_ADDR: nxt_s.remain[31:24] = reg_wdata;
        LEN2_ADDR: nxt_s.remain[23:16] = reg_wdata;
        LEN1_ADDR: nxt_s.remain[15:8] = reg_wdata;
        LEN0_ADDR: nxt_s.remain[7:0] = reg_wdata;
        EVT_ADDR:  nxt_s.ev = s_ff.ev & ~reg_wdata[2:0];
        WRP_ADDR:  nxt_s.wdata = reg_wdata;
        default: ;
      endcase
    end
    // Read data, valid only in the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        JOIN_ADDR: nxt_s.rdata = s_ff.link & JOIN_MASK;
        CFGA_ADDR: nxt_s.rdata = {s_ff.ack_lim, s_ff.speed, s_ff.tog, s_ff.run};
        CFGB_ADDR: nxt_s.rdata = {s_ff.token, 2'h0, s_ff.auto_z, 2'h0, s_ff.unlim};
        MPSH_ADDR: nxt_s.rdata = {6'h00, s_ff.mps[9:8]};
        MPSL_ADDR: nxt_s.rdata = s_ff.mps[7:0];
        LEN3_ADDR: nxt_s.rdata = s_ff.remain[31:24];
        LEN2_ADDR: nxt_s.rdata = s_ff.remain[23:16];
        LEN1_ADDR: nxt_s.rdata = s_ff.remain[15:8];
        LEN0_ADDR: nxt_s.rdata = s_ff.remain[7:0];
        EVT_ADDR:  nxt_s.rdata = {5'h00, s_ff.ev};
        RES_ADDR:  nxt_s.rdata = {1'h0, s_ff.rc, 4'h0};
        RDP_ADDR:  nxt_s.rdata = s_ff.link[CRD_BIT] ? fifo_rdata : 8'h00;
        RCNT_ADDR: nxt_s.rdata = fifo_level[7:0];
        WCNT_ADDR: nxt_s.rdata = fifo_space[7:0];
        default:   nxt_s.rdata = 8'h00;
      endcase
    end
    // Transaction engine
    case (s_ff.st)
      ST_IDLE: begin
        if (s_ff.run) begin
          nxt_s.st = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        nxt_s.start   = 1'b1;
        nxt_s.is_out  = setup_sequencer_launch ? sequencer_is_out : (s_ff.token == TOKEN_OUT);
        nxt_s.fs      = s_ff.speed == SPEED_FS;
        nxt_s.tog_out = s_ff.tog;
        nxt_s.zlen    = s_ff.zlp_pend;
        nxt_s.len     = s_ff.zlp_pend ? 11'h000 : pkt_len(s_ff.remain, s_ff.mps, s_ff.unlim);
        nxt_s.st      = ST_WAIT;
      end
      ST_WAIT: begin
        if (txn_done) begin
          nxt_s.got   = txn_bytes;
          nxt_s.acked = txn_acked & (!bulk_only_active | bulk_data_phase);
          nxt_s.st    = ST_JUDGE;
        end
      end
      ST_JUDGE: begin
        nxt_s.zlp_pend = 1'b0;
        if (code != RC_OK) begin
          nxt_s.rc          = code;
          nxt_s.ev[EV_CHG]  = 1'b1;
          nxt_s.run         = 1'b0;
          nxt_s.st          = ST_IDLE;
        end else begin
          nxt_s.tog = ~s_ff.tog;
          ack_next  = s_ff.ack_cnt + 4'h1;
          if (s_ff.acked) begin
            if (ack_next == s_ff.ack_lim) begin
              nxt_s.ev[EV_ACK] = 1'b1;
              nxt_s.ack_cnt    = 4'h0;
            end else begin
              nxt_s.ack_cnt = ack_next;
            end
          end
          if (!s_ff.unlim) begin
            new_rem      = (s_ff.remain > {21'h00_0000, s_ff.got}) ? s_ff.remain - {21'h00_0000, s_ff.got} : 32'h0000_0000;
            nxt_s.remain = new_rem;
            fin = (new_rem == 32'h0000_0000) || (!s_ff.is_out && s_ff.got < {1'b0, s_ff.mps});
          end
          if (fin && !s_ff.zlen && s_ff.is_out && s_ff.auto_z && s_ff.got == {1'b0, s_ff.mps}) begin
            nxt_s.zlp_pend = 1'b1;
            nxt_s.st       = ST_ISSUE;
          end else if (fin) begin
            nxt_s.ev[EV_DONE] = 1'b1;
            nxt_s.run         = 1'b0;
            nxt_s.st          = ST_IDLE;
          end else if (!s_ff.run) begin
            nxt_s.rc         = RC_OK;
            nxt_s.ev[EV_CHG] = 1'b1;
            nxt_s.st         = ST_IDLE;
          end else begin
            nxt_s.st = ST_ISSUE;
          end
        end
      end
      default: nxt_s.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff         <= '0;
      s_ff.st      <= ST_IDLE;
      s_ff.link    <= JOIN_RST;
      s_ff.ack_lim <= CFGA_RST[ACK_LSB +: 4];
      s_ff.token   <= CFGB_RST[TOK_LSB +: 2];
      s_ff.mps     <= MPS_RST;
      s_ff.remain  <= LEN_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata            = s_ff.rdata;
  assign fifo_wdata           = s_ff.wdata;
  assign fifo_push            = jif.push;
  assign fifo_pop             = jif.pop;
  assign dma_leftover_count0  = jif.left0;
  assign dma_leftover_count1  = jif.left1;
  assign fifo_event_full      = jif.ev_full;
  assign fifo_event_empty     = jif.ev_empty;
  assign fifo_event_not_empty = jif.ev_not_empty;
  assign txn_start            = s_ff.start;
  assign txn_is_out           = s_ff.is_out;
  assign txn_full_speed       = s_ff.fs;
  assign txn_toggle           = s_ff.tog_out;
  assign txn_len              = s_ff.len;
  assign txn_zero_len         = s_ff.zlen;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  link_onehot_a: assert property ($onehot0(s_ff.link[3:0]))
    else $error("more than one data link set");
  ack_reach_a: assert property (s_ff.st == ST_JUDGE && code == RC_OK && s_ff.acked
    && s_ff.ack_cnt + 4'h1 == s_ff.ack_lim |=> s_ff.ev[EV_ACK] && s_ff.ack_cnt == 4'h0)
    else $error("handshake limit not flagged");
  speed_out_a: assert property (s_ff.start |-> s_ff.fs == ($past(s_ff.speed) == SPEED_FS))
    else $error("speed select not applied");
  toggle_seed_a: assert property (s_ff.start |-> s_ff.tog_out == $past(s_ff.tog))
    else $error("toggle seed wrong");
  run_start_a: assert property (s_ff.st == ST_IDLE && s_ff.run |=> s_ff.st == ST_ISSUE ##1 s_ff.start)
    else $error("run bit did not start a transaction");
  done_stop_a: assert property ($rose(s_ff.ev[EV_DONE]) |-> !s_ff.run && s_ff.st == ST_IDLE)
    else $error("run bit kept after completion");
  change_stop_a: assert property ($rose(s_ff.ev[EV_CHG]) |-> !s_ff.run && s_ff.rc == $past(code))
    else $error("run bit kept after result change");
  stop_finish_a: assert property (s_ff.st == ST_WAIT && !s_ff.run && txn_done
    |-> ##2 (s_ff.ev[EV_CHG] || s_ff.ev[EV_DONE] || s_ff.zlp_pend))
    else $error("stop did not end with a flag");
  token_out_a: assert property (s_ff.start && !$past(setup_sequencer_launch)
    |-> s_ff.is_out == ($past(s_ff.token) == TOKEN_OUT))
    else $error("token kind not applied");
  empty_pkt_a: assert property (s_ff.start && s_ff.zlen |-> s_ff.len == 11'h000 && s_ff.is_out)
    else $error("empty packet malformed");
  unlimited_keep_a: assert property (s_ff.unlim && s_ff.st == ST_JUDGE && !reg_wr
    |=> s_ff.remain == $past(s_ff.remain) && !s_ff.ev[EV_DONE] || $past(s_ff.ev[EV_DONE]))
    else $error("unlimited length changed count");
  reserved_zero_a: assert property (reg_rd && reg_addr == CFGB_ADDR |=> (reg_rdata & ~CFGB_MASK) == 8'h00)
    else $error("reserved bits read nonzero");
  // Register port views and run start
  read_port_a: assert property (reg_rd && reg_addr == RDP_ADDR && s_ff.link[CRD_BIT]
    |=> reg_rdata == $past(fifo_rdata))
    else $error("read port data not passed");
  count_read_a: assert property (reg_rd && reg_addr == RCNT_ADDR
    |=> reg_rdata == $past(fifo_level[7:0]))
    else $error("read count not shown");
  len_write_a: assert property (reg_wr && reg_addr == LEN0_ADDR && s_ff.st != ST_JUDGE
    |=> s_ff.remain[7:0] == $past(reg_wdata))
    else $error("length byte not written");
  run_go_a: assert property (reg_wr && reg_addr == CFGA_ADDR && reg_wdata[RUN_BIT] && !s_ff.run
    && s_ff.st == ST_IDLE |=> s_ff.run ##1 s_ff.st == ST_ISSUE)
    else $error("run write did not start");
  done_seen_c: cover property ($rose(s_ff.ev[EV_DONE]));
  retry_seen_c: cover property ($rose(s_ff.ev[EV_CHG]) && s_ff.rc == RC_RETRY);
  ack_seen_c: cover property ($rose(s_ff.ev[EV_ACK]));
  empty_pkt_c: cover property (s_ff.start && s_ff.zlen);
  stop_seen_c: cover property ($rose(s_ff.ev[EV_CHG]) && s_ff.rc == RC_OK);
endmodule

// file: core/usb_chan_pkg.sv
package usb_chan_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [9:0] JOIN_ADDR  = 10'h12f;
  localparam logic [9:0] CFGA_ADDR  = 10'h130;
  localparam logic [9:0] CFGB_ADDR  = 10'h131;
  localparam logic [9:0] MPSH_ADDR  = 10'h132;
  localparam logic [9:0] MPSL_ADDR  = 10'h133;
  localparam logic [9:0] LEN3_ADDR  = 10'h134;
  localparam logic [9:0] LEN2_ADDR  = 10'h135;
  localparam logic [9:0] LEN1_ADDR  = 10'h136;
  localparam logic [9:0] LEN0_ADDR  = 10'h137;
  localparam logic [9:0] EVT_ADDR   = 10'h138;
  localparam logic [9:0] RES_ADDR   = 10'h139;
  localparam logic [9:0] RDP_ADDR   = 10'h13a;
  localparam logic [9:0] WRP_ADDR   = 10'h13b;
  localparam logic [9:0] RCNT_ADDR  = 10'h13c;
  localparam logic [9:0] WCNT_ADDR  = 10'h13d;
  // ==========================================================
  // Field positions
  localparam int MON_BIT   = 6;
  localparam int DMA1_BIT  = 3;
  localparam int DMA0_BIT  = 2;
  localparam int CRD_BIT   = 1;
  localparam int CWR_BIT   = 0;
  localparam int ACK_LSB   = 4;
  localparam int SPD_LSB   = 2;
  localparam int TOG_BIT   = 1;
  localparam int RUN_BIT   = 0;
  localparam int TOK_LSB   = 6;
  localparam int AUTOZ_BIT = 3;
  localparam int UNLIM_BIT = 0;
  localparam int RC_LSB    = 4;
  localparam int EV_DONE   = 0;
  localparam int EV_ACK    = 1;
  localparam int EV_CHG    = 2;
  // ==========================================================
  // Masks, reset values, encodings
  localparam logic [7:0]  JOIN_MASK = 8'h4f;
  localparam logic [7:0]  CFGB_MASK = 8'hc9;
  localparam logic [7:0]  JOIN_RST  = 8'h00;
  localparam logic [7:0]  CFGA_RST  = 8'h10;
  localparam logic [7:0]  CFGB_RST  = 8'h00;
  localparam logic [9:0]  MPS_RST   = 10'h000;
  localparam logic [31:0] LEN_RST   = 32'h0000_0000;
  localparam logic [2:0]  RC_OK     = 3'h0;
  localparam logic [2:0]  RC_STALL  = 3'h1;
  localparam logic [2:0]  RC_RETRY  = 3'h4;
  localparam logic [1:0]  SPEED_FS  = 2'h1;
  localparam logic [1:0]  TOKEN_OUT = 2'h1;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ISSUE = 4'h2,
    ST_WAIT  = 4'h4,
    ST_JUDGE = 4'h8
  } eng_state_type;
endpackage

// file: core/fifo_join_if.sv
`timescale 1ns/1ps
// FIFO routing signals between register core and router
interface fifo_join_if #(parameter int LW = 10);
  logic [7:0]    join_bits;
  logic [1:0]    dma_req;
  logic [1:0]    dma_dir;
  logic          cpu_rd;
  logic          cpu_wr;
  logic          full;
  logic          empty;
  logic [LW-1:0] level;
  logic [LW-1:0] space;
  logic          push;
  logic          pop;
  logic          ev_full;
  logic          ev_empty;
  logic          ev_not_empty;
  logic [LW-1:0] left0;
  logic [LW-1:0] left1;
  modport core  (output join_bits, dma_req, dma_dir, cpu_rd, cpu_wr, full, empty, level, space,
                 input push, pop, ev_full, ev_empty, ev_not_empty, left0, left1);
  modport route (input join_bits, dma_req, dma_dir, cpu_rd, cpu_wr, full, empty, level, space,
                 output push, pop, ev_full, ev_empty, ev_not_empty, left0, left1);
endinterface

// file: core/result_classify.sv
`timescale 1ns/1ps
module result_classify
  import usb_chan_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       done,
  input  wire logic       stall,
  input  wire logic       timeout,
  input  wire logic       crc_err,
  input  wire logic       stuff_err,
  input  wire logic       pid_fail,
  input  wire logic       pid_bad,
  input  wire logic       toggle_err,
  output logic      [2:0] code
);
  typedef struct packed {
    logic [2:0] code;
  } cls_state_type;
  cls_state_type s_ff, nxt_s;
  logic          pkt_bad;

  // ==========================================================
  // Result code capture on transaction end
  always_comb begin
    nxt_s   = s_ff;
    pkt_bad = crc_err | stuff_err | pid_fail | pid_bad | toggle_err;
    if (done) begin
      if (stall) begin
        nxt_s.code = RC_STALL;
      end else if (timeout | pkt_bad) begin
        nxt_s.code = RC_RETRY;
      end else begin
        nxt_s.code = RC_OK;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign code = s_ff.code;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  no_reply_a: assert property (done && timeout && !stall |=> code == RC_RETRY)
    else $error("timeout did not give retry code");
  bad_packet_a: assert property (done && !stall && (crc_err || stuff_err || pid_fail || pid_bad || toggle_err)
    |=> code == RC_RETRY)
    else $error("packet fault did not give retry code");
endmodule

// file: core/fifo_join_route.sv
`timescale 1ns/1ps
module fifo_join_route
  import usb_chan_pkg::*;
#(
  parameter int LW = 10
)(
  input  wire logic clk,
  input  wire logic rst_n,
  fifo_join_if.route jif
);
  typedef struct packed {
    logic          push;
    logic          pop;
    logic          full;
    logic          empty;
    logic          not_empty;
    logic [LW-1:0] left0;
    logic [LW-1:0] left1;
  } rte_state_type;
  rte_state_type s_ff, nxt_s;
  logic          sel0;
  logic          sel1;

  // Leftover view of one DMA channel
  function automatic logic [LW-1:0] leftover(input logic sel, input logic dir,
                                             input logic [LW-1:0] lvl, input logic [LW-1:0] spc);
    if (!sel) begin
      return '0;
    end
    return dir ? lvl : spc;
  endfunction

  // ==========================================================
  // Strobe routing and flag monitor
  always_comb begin
    nxt_s = s_ff;
    sel0  = jif.join_bits[DMA0_BIT];
    sel1  = jif.join_bits[DMA1_BIT];
    nxt_s.pop  = !jif.empty & ((jif.cpu_rd & jif.join_bits[CRD_BIT])
                 | (sel0 & jif.dma_req[0] & jif.dma_dir[0])
                 | (sel1 & jif.dma_req[1] & jif.dma_dir[1]));
    nxt_s.push = !jif.full & ((jif.cpu_wr & jif.join_bits[CWR_BIT])
                 | (sel0 & jif.dma_req[0] & !jif.dma_dir[0])
                 | (sel1 & jif.dma_req[1] & !jif.dma_dir[1]));
    nxt_s.full      = jif.join_bits[MON_BIT] & jif.full;
    nxt_s.empty     = jif.join_bits[MON_BIT] & jif.empty;
    nxt_s.not_empty = jif.join_bits[MON_BIT] & !jif.empty;
    nxt_s.left0 = leftover(sel0, jif.dma_dir[0], jif.level, jif.space);
    nxt_s.left1 = leftover(sel1, jif.dma_dir[1], jif.level, jif.space);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign jif.push         = s_ff.push;
  assign jif.pop          = s_ff.pop;
  assign jif.ev_full      = s_ff.full;
  assign jif.ev_empty     = s_ff.empty;
  assign jif.ev_not_empty = s_ff.not_empty;
  assign jif.left0        = s_ff.left0;
  assign jif.left1        = s_ff.left1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  monitor_flags_a: assert property (jif.join_bits[MON_BIT] && jif.full |=> jif.ev_full && !jif.ev_empty)
    else $error("monitor link did not pass full flag");
  dma_move_a: assert property (jif.join_bits[DMA0_BIT] && jif.dma_req[0] && jif.dma_dir[0]
    && !jif.empty |=> jif.pop && !jif.push)
    else $error("joined DMA read did not pop");
endmodule

// file: tb/usb_dev_model.sv
`timescale 1ns/1ps
module usb_dev_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        txn_start,
  input  wire logic [10:0] txn_len,
  input  wire logic [2:0]  fault,
  input  wire logic        slow,
  output logic             txn_done,
  output logic             txn_acked,
  output logic      [10:0] txn_bytes,
  output logic      [5:0]  errs
);
  logic [5:0] cnt_ff;
  wire         fin = (cnt_ff == 6'h01);
  // Answers each token after a short or long pause; levels scrambled outside the answer cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 6'h00;
      txn_done <= 1'b0;
      txn_acked <= 1'b0;
      txn_bytes <= 11'h000;
      errs <= 6'h00;
    end else begin
      txn_done <= fin;
      txn_acked <= fin ? (fault == 3'h0) : ~txn_acked;
      txn_bytes <= fin ? ((fault == 3'h0) ? txn_len : 11'h000) : ~txn_bytes;
      errs <= fin ? ((fault == 3'h0) ? 6'h00 : 6'h01 << (fault - 3'h1)) : ~errs; // No reply or bad packet
      cnt_ff <= txn_start ? (slow ? 6'h28 : 6'h03) : (cnt_ff != 6'h00) ? cnt_ff - 6'h01 : 6'h00;
    end
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import usb_chan_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
  logic [9:0] reg_addr = 10'h000, fifo_level = 10'h000, fifo_space = 10'h000, lo0, lo1;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, got, fifo_rdata = 8'h00, fifo_wdata;
  logic fifo_full = 1'b0, fifo_empty = 1'b1, fifo_push, fifo_pop, ev_f, ev_e, ev_ne, is_out, fs, tog, zl;
  logic [1:0] dma_req = 2'h0, dma_direction_bit = 2'h0;
  logic [2:0] fault = 3'h0;
  logic [10:0] txn_len, txn_bytes;
  logic [5:0] errs;
  logic txn_start, txn_done, txn_acked;
  int n_fail = 0, samples_checked = 0, cycles = 0, rem, zlp_seen = 0;
  integer seed = 32'hb528;
  usb_host_channel_setup dut_u (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .fifo_rdata, .fifo_wdata, .fifo_push, .fifo_pop, .fifo_full, .fifo_empty,
    .fifo_level, .fifo_space, .dma_req, .dma_direction_bit, .dma_leftover_count0(lo0),
    .dma_leftover_count1(lo1), .fifo_event_full(ev_f), .fifo_event_empty(ev_e), .fifo_event_not_empty(ev_ne),
    .setup_sequencer_launch(1'b0), .sequencer_is_out(1'b0), .bulk_only_active(1'b0), .bulk_data_phase(1'b0),
    .txn_start, .txn_is_out(is_out), .txn_full_speed(fs), .txn_toggle(tog), .txn_len, .txn_zero_len(zl), .txn_done,
    .txn_acked, .txn_bytes, .txn_stall(1'b0), .txn_timeout(errs[0]), .txn_crc_err(errs[1]),
    .txn_stuff_err(errs[2]), .txn_pid_fail(errs[3]), .txn_pid_bad(errs[4]), .txn_toggle_err(errs[5]));
  usb_dev_model dev_u (.clk, .rst_n, .txn_start, .txn_len, .fault, .slow, .txn_done, .txn_acked, .txn_bytes, .errs);
  // Clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (txn_start && zl) zlp_seen++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end
  // ==========================================
  // Bus tasks and comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (exp !== seen) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
    if (what != "") chk(what, exp, got);
  endtask
  task automatic run(input logic [7:0] cfg);
    wr(LEN0_ADDR, 8'h10);
    go(cfg);
  endtask
  task automatic go(input logic [7:0] cfg);
    wr(CFGA_ADDR, cfg);
    got = 8'h01;
    for (int i = 0; i < 100 && got[0] !== 1'b0; i++) rd(CFGA_ADDR, 8'h00, "");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(JOIN_ADDR, 8'h00, "link reset");
    rd(CFGA_ADDR, 8'h10, "cfg_a reset");
    rd(CFGB_ADDR, 8'h00, "cfg_b reset");
    wr(JOIN_ADDR, 8'hff);
    rd(JOIN_ADDR, 8'h48, "link all"); // Highest link kept
    wr(JOIN_ADDR, 8'h03);
    rd(JOIN_ADDR, 8'h02, "link two"); // Highest link kept
    wr(CFGB_ADDR, 8'hff);
    rd(CFGB_ADDR, 8'hc9, "cfg_b mask"); // Reserved zero
    wr(CFGB_ADDR, 8'h40);
    wr(JOIN_ADDR, 8'h04);
    for (int d = 0; d < 2; d++) begin
      @(posedge clk);
      dma_direction_bit <= 2'(d);
      dma_req <= 2'h1;
      fifo_empty <= 1'b0;
      fifo_rdata <= 8'($random(seed));
      fifo_level <= 10'($random(seed));
      fifo_space <= 10'($random(seed));
      repeat (3) @(posedge clk);
      chk("leftover", d ? fifo_level : fifo_space, lo0); // Leftover by direction
      chk("leftover other", 0, lo1); // Unlinked DMA shows zero
      chk("dma strobe", {d == 1, d == 0}, {fifo_pop, fifo_push}); // Move by direction
    end
    dma_req <= 2'h0;
    wr(JOIN_ADDR, 8'h42);
    fifo_full <= 1'b1;
    rd(RDP_ADDR, fifo_rdata, "fifo read"); // Read link
    chk("pop and flags", 4'hd, {fifo_pop, ev_f, ev_e, ev_ne});
    rd(RCNT_ADDR, 8'(fifo_level), "read count");
    wr(JOIN_ADDR, 8'h01);
    fifo_full <= 1'b0;
    wr(WRP_ADDR, 8'h5a);
    #1 chk("push", 9'h15a, {fifo_push, fifo_wdata}); // Write link
    wr(MPSL_ADDR, 8'h08);
    rem = 16;
    run(8'h21);
    rem = rem - 2 * 8;
    rd(EVT_ADDR, 8'h03, "events"); // Done and ack limit
    rd(CFGA_ADDR, 8'h20, "cfg_a after"); // Run cleared, toggle back
    rd(LEN0_ADDR, 8'(rem), "remaining"); // Length low byte
    for (int f = 1; f < 7; f++) begin
      @(posedge clk);
      fault <= 3'(f);
      slow <= f[0];
      wr(EVT_ADDR, 8'h07);
      run(8'h11);
      rd(RES_ADDR, 8'h40, "result"); // Retry code
      rd(EVT_ADDR, 8'h04, "changed"); // Result change clears run
      rd(LEN0_ADDR, 8'h10, "kept length"); // Length kept
    end
    @(posedge clk);
    fault <= 3'h0;
    slow <= 1'b1;
    wr(EVT_ADDR, 8'h07);
    wr(LEN0_ADDR, 8'h10);
    wr(CFGA_ADDR, 8'h15);
    repeat (5) @(posedge clk);
    chk("fields", 15'h6008, {is_out, fs, tog, zl, txn_len}); // Seeded fields
    wr(CFGA_ADDR, 8'h14);
    repeat (60) @(posedge clk);
    rd(EVT_ADDR, 8'h06, "stop events"); // Stop flags after finish
    rd(RES_ADDR, 8'h00, "stop code");
    rd(LEN0_ADDR, 8'h08, "stop length");
    rd(CFGA_ADDR, 8'h16, "stop cfg_a");
    wr(CFGB_ADDR, 8'h48);
    wr(EVT_ADDR, 8'h07);
    go(8'h17);
    rd(EVT_ADDR, 8'h03, "resume events"); // Resume to end
    chk("empty packets", 1, zlp_seen);
    wr(CFGB_ADDR, 8'h81);
    wr(EVT_ADDR, 8'h07);
    wr(CFGA_ADDR, 8'h15);
    repeat (60) @(posedge clk);
    chk("in token", 0, is_out);
    wr(CFGA_ADDR, 8'h14);
    repeat (60) @(posedge clk);
    rd(EVT_ADDR, 8'h06, "unlimited events"); // No done flag
    rd(LEN0_ADDR, 8'h00, "unlimited length");
    close_out();
  end
endmodule
